// ### design/csm_supply_mode_fault_manager.sv
// Purpose: Mode control, supply steering and bus fault supervision of the transceiver.
// Assumes: All inputs synchronous to clk; registers reached over AXI4-Lite.
// Notes:   Outputs are registered copies of the next state, so they agree with st.
//
// Contract
// - Sleep: regulators off, bus standby, timer optional
// - Power select 11: only MCU supply, oscillator stopped
// - Power select 10: MCU supply, slow oscillator
// - Power select 00: MCU supply, fast oscillator, reset default
// - Receive-only: transceiver supply, idle returns sleep
// - Normal: all supplies, fast oscillator, full bus
// - Low-oscillator standby needs startup ack; select 11 also needs watchdog off
// - Peripheral supply follows enable bit, tracking option
// - Transceiver supply follows its enable bit
// - Reset held high keeps MCU supply alive
// - Long transmit dominant blocks further transmission
// - Both wires dominant too long is type ten
// - Leave sleep on local wake or bus dominant
// - Edge count difference above three flags open
// - Overvoltage held 32us flags types three, six
// - Low wire low and negative held flags four; code reports seven, both filters fire together
// - Negative differential held flags type seven
// - High wire high and negative held flags eight
// - Types one, two, four, eight: differential transmit
// - Types one, two, five, nine: differential receive
// - Types three, six: single-wire on healthy wire
// - Dominant drives the wires, recessive releases them
// - Error flag and fault type readable in register
`timescale 1ns/10ps
module csm_supply_mode_fault_manager #(
	parameter int SHORT_TIME = csm_pkg::SHORT_CYC,
	parameter int VDD_TIME   = csm_pkg::VDD_CYC,
	parameter int IDLE_TIME  = csm_pkg::IDLE_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire csm_pkg::csm_axi_req_t axi_req,
	output      csm_pkg::csm_axi_rsp_t axi_rsp,
	input  wire csm_pkg::csm_sense_t   sense,
	input  wire logic                 txd_n,
	input  wire logic                 reset_hold_ext,
	output      csm_pkg::csm_supply_t  supply,
	output      csm_pkg::csm_line_t    line,
	output      logic                 fault_flag
);
	import csm_pkg::*;

	localparam int NCOND = 7;

	typedef struct packed {
		csm_axi_rsp_t          rsp;
		logic                  aw_held;
		logic [7:0]            aw_addr;
		logic                  w_held;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		csm_ctrl_t             ctrl;
		csm_mode_t             mode;
		logic [1:0]            lp_eff;
		logic                  tx_blocked;
		logic [3:0]            code;
		logic                  flag;
		logic signed [3:0]     edge_diff;
		logic                  h_prev;
		logic                  l_prev;
		logic [15:0]           idle_cnt;
		logic [NCOND-1:0][15:0] cnt;
		csm_supply_t           sup;
		csm_line_t             ln;
	} csm_state_t;

	csm_state_t           st;
	csm_state_t           nxt_st;
	logic [NCOND-1:0]     cond;
	logic [NCOND-1:0]     fire;
	logic [NCOND-1:0][15:0] limit;
	logic [NCOND-1:0][3:0]  ccode;

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic known(input logic [7:0] a);
		return (a == CTRL_OFS) || (a == STAT_OFS) || (a == FAULT_OFS);
	endfunction : known

	// Persistence filters: a condition counts while present and fires once.
	assign cond = {~txd_n, sense.canh_dom & sense.canl_dom, sense.canh_high & sense.diff_neg,
		sense.diff_neg, sense.canl_low & sense.diff_neg, sense.canl_ovv, sense.canh_ovv};
	assign limit = {16'(SHORT_TIME), 16'(SHORT_TIME), 16'(VDD_TIME), 16'(SHORT_TIME),
		16'(SHORT_TIME), 16'(OVV_CYC), 16'(OVV_CYC)};
	assign ccode = {F_NONE, F_PROTO, F_H_VDD, F_SHORT, F_L_GND, F_L_BAT, F_H_BAT};

	genvar g;
	generate
		for (g = 0; g < NCOND; g++)
		begin : g_fire
			assign fire[g] = cond[g] && (st.cnt[g] == limit[g] - 16'h0001);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		csm_stat_t  s;
		csm_fault_t f;
		logic       wr;
		logic       h_fall;
		logic       l_fall;
		logic       bus_dom;
		logic       mode_wr;
		csm_ctrl_t  wc;
		s = '0;
		f = '0;
		wc = '0;
		wr = 1'b0;
		h_fall = 1'b0;
		l_fall = 1'b0;
		bus_dom = 1'b0;
		mode_wr = 1'b0;
		nxt_st = st;
		nxt_st.rsp.bvalid = st.rsp.bvalid && !axi_req.bready;
		nxt_st.rsp.rvalid = st.rsp.rvalid && !axi_req.rready;
		nxt_st.ctrl.local_wake = 1'b0;

		// Write address and data are caught separately, in either order.
		if (axi_req.awvalid && st.rsp.awready)
		begin
			nxt_st.aw_held = 1'b1;
			nxt_st.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && st.rsp.wready)
		begin
			nxt_st.w_held = 1'b1;
			nxt_st.w_data = axi_req.wdata;
			nxt_st.w_strb = axi_req.wstrb;
		end
		wr = st.aw_held && st.w_held && !st.rsp.bvalid;
		if (wr)
		begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.rsp.bvalid = 1'b1;
			nxt_st.rsp.bresp = known(st.aw_addr) ? RESP_OK : RESP_ERR;
			if (st.aw_addr == CTRL_OFS)
			begin
				wc = csm_ctrl_t'(merge(st.ctrl, st.w_data, st.w_strb));
				wc.rsvd = '0;
				nxt_st.ctrl = wc;
				mode_wr = st.w_strb[0];
			end
		end
		nxt_st.rsp.awready = !nxt_st.aw_held;
		nxt_st.rsp.wready = !nxt_st.w_held;

		s.mode = st.mode;
		s.v1 = st.sup.mcu_supply_regulator;
		s.v2 = st.sup.peripheral_supply_regulator;
		s.v3 = st.sup.transceiver_supply_regulator;
		s.osc_run = st.sup.osc_run;
		s.osc_fast = st.sup.osc_fast;
		s.timer_run = st.sup.timer_run;
		s.tx_blocked = st.tx_blocked;
		s.single_wire = (st.code == F_H_BAT) || (st.code == F_L_BAT);
		f.code = st.code;
		f.flag = st.flag;
		if (axi_req.arvalid && st.rsp.arready)
		begin
			nxt_st.rsp.rvalid = 1'b1;
			nxt_st.rsp.rresp = known(axi_req.araddr) ? RESP_OK : RESP_ERR;
			unique case (axi_req.araddr)
				CTRL_OFS:  nxt_st.rsp.rdata = st.ctrl;
				STAT_OFS:  nxt_st.rsp.rdata = s;
				FAULT_OFS: nxt_st.rsp.rdata = f;
				default:   nxt_st.rsp.rdata = '0;
			endcase
		end
		nxt_st.rsp.arready = !nxt_st.rsp.rvalid;

		h_fall = st.h_prev && !sense.canh_dom;
		l_fall = st.l_prev && !sense.canl_dom;
		nxt_st.h_prev = sense.canh_dom;
		nxt_st.l_prev = sense.canl_dom;
		if (l_fall && !h_fall)
		begin
			nxt_st.edge_diff = st.edge_diff + 4'sd1;
		end
		else if (h_fall && !l_fall)
		begin
			nxt_st.edge_diff = st.edge_diff - 4'sd1;
		end

		// flag clears by writing one; a fault in the same cycle wins.
		if (wr && (st.aw_addr == FAULT_OFS) && st.w_strb[0] && st.w_data[0])
		begin
			nxt_st.flag = 1'b0;
		end
		// latest detected type replaces the code
		if ($signed(nxt_st.edge_diff) > $signed(4'(EDGE_DIFF_MAX)))
		begin
			nxt_st.code = F_H_OPEN;
			nxt_st.flag = 1'b1;
			nxt_st.edge_diff = '0;
		end
		else if ($signed(nxt_st.edge_diff) < -$signed(4'(EDGE_DIFF_MAX)))
		begin
			nxt_st.code = F_L_OPEN;
			nxt_st.flag = 1'b1;
			nxt_st.edge_diff = '0;
		end
		for (int i = 0; i < NCOND; i++)
		begin
			nxt_st.cnt[i] = !cond[i] ? 16'h0000 : (st.cnt[i] == limit[i]) ? st.cnt[i] : st.cnt[i] + 16'h0001;
			if (fire[i] && (ccode[i] != F_NONE))
			begin
				nxt_st.code = ccode[i];
				nxt_st.flag = 1'b1;
			end
		end
		// stuck transmit blocks until the protocol unit releases
		if (fire[6])
		begin
			nxt_st.tx_blocked = 1'b1;
		end
		else if (txd_n)
		begin
			nxt_st.tx_blocked = 1'b0;
		end

		bus_dom = sense.canh_dom || sense.canl_dom;
		nxt_st.idle_cnt = bus_dom ? 16'h0000 : st.idle_cnt + 16'h0001;
		unique case (st.mode)
			SLEEP:
			begin
				// wake on local request or bus dominant
				if (st.ctrl.local_wake || bus_dom)
				begin
					nxt_st.mode = NORMAL;
				end
			end
			RECEIVE_ONLY_MODE:
			begin
				// idle bus falls back to sleep
				if (st.idle_cnt >= 16'(IDLE_TIME - 1))
				begin
					nxt_st.mode = SLEEP;
				end
			end
			default:
			begin
				nxt_st.mode = st.mode;
			end
		endcase
		if (mode_wr)
		begin
			nxt_st.mode = csm_mode_t'(wc.mode_req);
			nxt_st.idle_cnt = '0;
		end

		// low-oscillator variants need an acknowledged startup
		nxt_st.lp_eff = 2'h0;
		if (nxt_st.ctrl.start_ack && nxt_st.ctrl.standby_power_select == 2'h2)
		begin
			nxt_st.lp_eff = 2'h2;
		end
		else if (nxt_st.ctrl.start_ack && nxt_st.ctrl.wd_dis && nxt_st.ctrl.standby_power_select == 2'h3)
		begin
			nxt_st.lp_eff = 2'h3;
		end

		nxt_st.sup = '0;
		nxt_st.sup.peripheral_track = nxt_st.ctrl.v2_track;
		unique case (nxt_st.mode)
			SLEEP:
			begin
				// all off, timer only when enabled
				// external reset hold keeps the MCU alive
				nxt_st.sup.mcu_supply_regulator = reset_hold_ext;
				nxt_st.sup.bus_standby = 1'b1;
				nxt_st.sup.osc_run = nxt_st.ctrl.timer_en;
				nxt_st.sup.timer_run = nxt_st.ctrl.timer_en;
			end
			STANDBY:
			begin
				nxt_st.sup.mcu_supply_regulator = 1'b1;
				nxt_st.sup.bus_standby = 1'b1;
				nxt_st.sup.osc_run = nxt_st.lp_eff != 2'h3;
				nxt_st.sup.osc_fast = nxt_st.lp_eff == 2'h0;
				nxt_st.sup.timer_run = nxt_st.lp_eff != 2'h3;
			end
			RECEIVE_ONLY_MODE:
			begin
				nxt_st.sup.mcu_supply_regulator = reset_hold_ext;
				nxt_st.sup.transceiver_supply_regulator = nxt_st.ctrl.v3_en;
				nxt_st.sup.osc_run = 1'b1;
				nxt_st.sup.osc_fast = 1'b1;
				nxt_st.sup.timer_run = 1'b1;
			end
			NORMAL:
			begin
				nxt_st.sup.mcu_supply_regulator = 1'b1;
				nxt_st.sup.peripheral_supply_regulator = nxt_st.ctrl.v2_en;
				nxt_st.sup.transceiver_supply_regulator = nxt_st.ctrl.v3_en;
				nxt_st.sup.osc_run = 1'b1;
				nxt_st.sup.osc_fast = 1'b1;
				nxt_st.sup.timer_run = 1'b1;
			end
		endcase

		// dominant drives; overvoltage wire is left idle
		nxt_st.ln.drive_h = (nxt_st.mode == NORMAL) && !txd_n && !nxt_st.tx_blocked && (nxt_st.code != F_H_BAT);
		nxt_st.ln.drive_l = (nxt_st.mode == NORMAL) && !txd_n && !nxt_st.tx_blocked && (nxt_st.code != F_L_BAT);
		// receive from the healthy wire or both
		nxt_st.ln.rx_n = 1'b1;
		if (nxt_st.mode == NORMAL || nxt_st.mode == RECEIVE_ONLY_MODE)
		begin
			nxt_st.ln.rx_n = (nxt_st.code == F_H_BAT) ? !sense.canl_dom :
				(nxt_st.code == F_L_BAT) ? !sense.canh_dom : !bus_dom;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st <= '0;
			st.ctrl <= csm_ctrl_t'(CTRL_RST);
			st.mode <= STANDBY;
			st.rsp.awready <= 1'b1;
			st.rsp.wready <= 1'b1;
			st.rsp.arready <= 1'b1;
			st.sup.mcu_supply_regulator <= 1'b1;
			st.sup.bus_standby <= 1'b1;
			st.sup.osc_run <= 1'b1;
			st.sup.osc_fast <= 1'b1;
			st.sup.timer_run <= 1'b1;
			st.ln.rx_n <= 1'b1;
		end
		else
		begin
			st <= nxt_st;
		end
	end

	assign axi_rsp = st.rsp;
	assign supply = st.sup;
	assign line = st.ln;
	assign fault_flag = st.flag;

	////////////////////////////////////////////////////////////////////////////////

	sequence ovv_held;
		sense.canh_ovv [*8];
	endsequence

	sleep_supplies_a: assert property (@(posedge clk) disable iff (rst)
		st.mode == SLEEP |-> !st.sup.peripheral_supply_regulator && !st.sup.transceiver_supply_regulator
		&& (st.sup.mcu_supply_regulator == $past(reset_hold_ext)) && st.sup.bus_standby)
		else $error("sleep supplies wrong");
	osc_stop_a: assert property (@(posedge clk) disable iff (rst)
		st.mode == STANDBY && st.lp_eff == 2'h3 |-> !st.sup.osc_run && !st.sup.timer_run)
		else $error("oscillator not stopped");
	lp_gate_a: assert property (@(posedge clk) disable iff (rst)
		st.lp_eff != 2'h0 |-> st.ctrl.start_ack && (st.lp_eff == 2'h2 || st.ctrl.wd_dis))
		else $error("standby variant without acknowledge");
	receive_only_mode_sup_a: assert property (@(posedge clk) disable iff (rst)
		st.mode == RECEIVE_ONLY_MODE && !$past(reset_hold_ext) |-> !st.sup.mcu_supply_regulator && st.sup.osc_fast)
		else $error("receive-only supplies wrong");
	normal_sup_a: assert property (@(posedge clk) disable iff (rst)
		st.mode == NORMAL |-> st.sup.mcu_supply_regulator && st.sup.osc_fast
		&& st.sup.peripheral_supply_regulator == st.ctrl.v2_en)
		else $error("normal supplies wrong");
	ovv_code_a: assert property (@(posedge clk) disable iff (rst)
		ovv_held ##0 (fire == 7'h01) |=> st.code == F_H_BAT && st.flag)
		else $error("overvoltage fault not coded");
	tx_block_a: assert property (@(posedge clk) disable iff (rst)
		fire[6] |=> st.tx_blocked && !st.ln.drive_h && !st.ln.drive_l)
		else $error("stuck transmit not blocked");
	wake_bus_a: assert property (@(posedge clk) disable iff (rst)
		st.mode == SLEEP && sense.canh_dom && !axi_req.awvalid && !st.aw_held |=> st.mode == NORMAL)
		else $error("bus wake missed");
	single_wire_a: assert property (@(posedge clk) disable iff (rst)
		st.code == F_H_BAT |-> !st.ln.drive_h)
		else $error("faulty wire driven");

endmodule : csm_supply_mode_fault_manager

// ### design/csm_pkg.sv
// Purpose: Shared types and constants for the supply mode and bus fault manager.
// Assumes: A 20 MHz system clock; comparator inputs already synchronous.
// Notes:   Register layouts are packed structs so bit positions are named once.
package csm_pkg;

	localparam int CLK_NS  = 50;
	localparam int CLK_MHZ = 20;

	localparam logic [7:0] CTRL_OFS  = 8'h00;
	localparam logic [7:0] STAT_OFS  = 8'h04;
	localparam logic [7:0] FAULT_OFS = 8'h08;

	localparam logic [31:0] CTRL_RST = 32'h0000_0091;

	localparam int OVV_US      = 32;
	localparam int OVV_CYC     = OVV_US * CLK_MHZ;
	localparam int SHORT_NS    = 1_300_000;
	localparam int SHORT_CYC   = SHORT_NS / CLK_NS;
	localparam int VDD_NS      = 2_500_000;
	localparam int VDD_CYC     = VDD_NS / CLK_NS;
	localparam int IDLE_US     = 1000;
	localparam int IDLE_CYC    = IDLE_US * CLK_MHZ;
	localparam int EDGE_DIFF_MAX = 3;

	localparam logic [3:0] F_NONE   = 4'h0;
	localparam logic [3:0] F_H_OPEN = 4'h1;
	localparam logic [3:0] F_L_OPEN = 4'h2;
	localparam logic [3:0] F_H_BAT  = 4'h3;
	localparam logic [3:0] F_L_GND  = 4'h4;
	localparam logic [3:0] F_L_BAT  = 4'h6;
	localparam logic [3:0] F_SHORT  = 4'h7;
	localparam logic [3:0] F_H_VDD  = 4'h8;
	localparam logic [3:0] F_PROTO  = 4'ha;

	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [1:0] {SLEEP, STANDBY, RECEIVE_ONLY_MODE, NORMAL} csm_mode_t;

	typedef struct packed {
		logic [20:0] rsvd;
		logic        wd_dis;
		logic        start_ack;
		logic        local_wake;
		logic        v3_en;
		logic        v2_track;
		logic        v2_en;
		logic        timer_en;
		logic [1:0]  standby_power_select;
		logic [1:0]  mode_req;
	} csm_ctrl_t;

	typedef struct packed {
		logic [21:0] rsvd;
		logic        single_wire;
		logic        tx_blocked;
		logic        timer_run;
		logic        osc_fast;
		logic        osc_run;
		logic        v3;
		logic        v2;
		logic        v1;
		logic [1:0]  mode;
	} csm_stat_t;

	typedef struct packed {
		logic [23:0] rsvd;
		logic [3:0]  code;
		logic [2:0]  rsvd2;
		logic        flag;
	} csm_fault_t;

	typedef struct packed {
		logic mcu_supply_regulator;
		logic peripheral_supply_regulator;
		logic peripheral_track;
		logic transceiver_supply_regulator;
		logic osc_run;
		logic osc_fast;
		logic timer_run;
		logic bus_standby;
	} csm_supply_t;

	typedef struct packed {
		logic canh_ovv;
		logic canl_ovv;
		logic canl_low;
		logic diff_neg;
		logic canh_high;
		logic canh_dom;
		logic canl_dom;
	} csm_sense_t;

	typedef struct packed {
		logic drive_h;
		logic drive_l;
		logic rx_n;
	} csm_line_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} csm_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} csm_axi_rsp_t;

endpackage : csm_pkg

// ### verification/csm_bus_model.sv
// Purpose: Other nodes on the two-wire bus as seen through the line comparators.
// Assumes: Wired bus, any active driver pulls both healthy wires dominant.
// Notes:   fault_sel picks which comparators a damaged wire trips; 0 is a healthy bus.
`timescale 1ns/10ps
module csm_bus_model (
	input  wire logic [3:0]         fault_sel,
	input  wire logic               other_dom,
	input  wire csm_pkg::csm_line_t line,
	output      csm_pkg::csm_sense_t sense
);
	import csm_pkg::*;
	logic dom;
	assign dom = other_dom | line.drive_h | line.drive_l;
	always_comb
	begin
		sense.canh_dom  = (dom && fault_sel != 4'h1) || fault_sel == 4'ha;
		sense.canl_dom  = (dom && fault_sel != 4'h2) || fault_sel == 4'ha;
		sense.canh_ovv  = fault_sel == 4'h3;
		sense.canl_ovv  = fault_sel == 4'h6;
		sense.canl_low  = fault_sel == 4'h4;
		sense.diff_neg  = fault_sel == 4'h4 || fault_sel == 4'h7 || fault_sel == 4'h8;
		sense.canh_high = fault_sel == 4'h8;
	end
endmodule : csm_bus_model

// ### verification/csm_supply_mode_fault_manager_tb.sv
// Purpose: Self-checking bench for mode, supply and fault supervision.
// Assumes: Short filter times set by parameters; overvoltage filter stays 640 cycles.
// Notes:   Supply vectors are compared masked where the timer state is left open.
`timescale 1ns/10ps
module csm_supply_mode_fault_manager_tb;
	import csm_pkg::*;
	logic          clk = 0;
	logic          rst = 1;
	csm_axi_req_t  req = '0;
	csm_axi_rsp_t  rsp;
	csm_sense_t    sense;
	logic          txd_n = 1;
	logic          reset_hold_ext = 0;
	csm_supply_t   supply;
	csm_line_t     line;
	logic          fault_flag;
	logic [3:0]    fault_sel = 4'h0;
	logic          other_dom = 0;
	int            error_cnt = 0;
	int            comparisons = 0;
	int            cycles = 0;
	logic [31:0]   v;
	logic [1:0]    resp;
	csm_supply_mode_fault_manager #(.SHORT_TIME(40), .VDD_TIME(80), .IDLE_TIME(50)) u_csm_supply_mode_fault_manager (
		.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .sense(sense), .txd_n(txd_n),
		.reset_hold_ext(reset_hold_ext), .supply(supply), .line(line), .fault_flag(fault_flag));
	csm_bus_model u_csm_bus_model (.fault_sel(fault_sel), .other_dom(other_dom), .line(line), .sense(sense));
	always #25 clk = ~clk;
	always @(posedge clk) cycles <= cycles + 1;
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic timeout;
		error_cnt++;
		end_of_test();
	endtask : timeout
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	// Each channel is released at the edge where it is seen taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit got;
		got = 0;
		@(posedge clk);
		req.awvalid <= 1;
		req.awaddr <= a;
		req.wvalid <= 1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1;
		for (int n = 0; n < 100 && !got; n++)
		begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 0;
			if (req.wvalid && rsp.wready) req.wvalid <= 0;
			if (req.bready && rsp.bvalid)
			begin
				got = 1;
				resp = rsp.bresp;
				req.bready <= 0;
			end
		end
		if (!got) timeout();
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bit got;
		got = 0;
		@(posedge clk);
		req.arvalid <= 1;
		req.araddr <= a;
		req.rready <= 1;
		for (int n = 0; n < 100 && !got; n++)
		begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 0;
			if (req.rready && rsp.rvalid)
			begin
				got = 1;
				d = rsp.rdata;
				resp = rsp.rresp;
				req.rready <= 0;
			end
		end
		if (!got) timeout();
		#1;
	endtask : rd
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(CTRL_OFS, v);
		chk(v, CTRL_RST);
		chk(supply, 8'h8f);
		rd(8'h0c, v);
		chk(v, 0);
		chk(resp, RESP_ERR);
	endtask : t_reset
	task automatic t_standby;
		wr(CTRL_OFS, 32'h0000_001d);
		cyc(2);
		chk(supply, 8'h8f);
		wr(CTRL_OFS, 32'h0000_060d);
		cyc(2);
		chk(supply, 8'h81);
		wr(CTRL_OFS, 32'h0000_0219);
		cyc(2);
		chk(supply, 8'h8b);
	endtask : t_standby
	// The bus stays quiet, so receive-only must drop back to sleep on its own.
	task automatic t_receive_only_mode_sleep;
		bit got;
		got = 0;
		wr(CTRL_OFS, 32'h0000_0092);
		cyc(1);
		chk(supply & 8'hfd, 8'h1c);
		for (int n = 0; n < 200 && !got; n++)
		begin
			cyc(1);
			got = !supply.transceiver_supply_regulator;
		end
		if (!got) timeout();
		chk(supply, 8'h0b);
		@(posedge clk) reset_hold_ext <= 1;
		cyc(3);
		chk(supply.mcu_supply_regulator, 1);
		@(posedge clk) reset_hold_ext <= 0;
		wr(CTRL_OFS, 32'h0000_0000);
		cyc(2);
		chk(supply, 8'h01);
		@(posedge clk) other_dom <= 1;
		@(posedge clk) other_dom <= 0;
		cyc(3);
		rd(STAT_OFS, v);
		chk(v[1:0], NORMAL);
		// Sleep request and local wake in one write: sleep first, then wake.
		wr(CTRL_OFS, 32'h0000_0100);
		cyc(2);
		rd(STAT_OFS, v);
		chk(v[1:0], NORMAL);
	endtask : t_receive_only_mode_sleep
	task automatic t_normal;
		wr(CTRL_OFS, 32'h0000_00b3);
		cyc(2);
		chk(supply & 8'hfd, 8'hdc);
		wr(CTRL_OFS, 32'h0000_00f3);
		cyc(2);
		chk(supply.peripheral_track, 1);
		@(posedge clk) txd_n <= 0;
		cyc(3);
		chk(line, 3'b110);
		@(posedge clk) txd_n <= 1;
		cyc(3);
		chk(line, 3'b001);
	endtask : t_normal
	// Elapsed time counts from t0, so bus traffic inside a wait does not shift it.
	task automatic wait_flag(input int t0, input int lo, input int hi);
		while (fault_flag !== 1'b1 && cycles - t0 < hi + 4)
		begin
			cyc(1);
		end
		chk(cycles - t0 >= lo && cycles - t0 <= hi, 1);
	endtask : wait_flag
	task automatic t_faults;
		logic [3:0] sel[6] = '{4'h3, 4'h6, 4'h4, 4'h7, 4'h8, 4'ha};
		logic [3:0] code[6] = '{4'h3, 4'h6, 4'h7, 4'h7, 4'h8, 4'ha};
		int         lim[6] = '{640, 640, 40, 40, 80, 40};
		int         t0;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk) fault_sel <= sel[i];
			t0 = cycles + 1;
			if (sel[i] == 4'h8)
			begin
				// The negative differential alone trips first, on the shorter filter.
				wait_flag(t0, 39, 42);
				rd(FAULT_OFS, v);
				chk(v[7:4], F_SHORT);
				wr(FAULT_OFS, 32'h0000_0001);
			end
			wait_flag(t0, lim[i] - 1, lim[i] + 2);
			rd(FAULT_OFS, v);
			chk(v[7:0], {code[i], 4'h1});
			rd(STAT_OFS, v);
			chk(v[9], sel[i] == 4'h3 || sel[i] == 4'h6);
			@(posedge clk) fault_sel <= 4'h0;
			wr(FAULT_OFS, 32'h0000_0001);
			cyc(2);
			chk(fault_flag, 0);
		end
		for (int k = 1; k <= 2; k++)
		begin
			@(posedge clk) fault_sel <= 4'(k);
			repeat (5)
			begin
				@(posedge clk) other_dom <= 1;
				@(posedge clk) other_dom <= 0;
				cyc(2);
			end
			wait_flag(cycles, 0, 20);
			rd(FAULT_OFS, v);
			chk(v[7:4], k);
			@(posedge clk) fault_sel <= 4'h0;
			wr(FAULT_OFS, 32'h0000_0001);
		end
	endtask : t_faults
	task automatic t_txblock;
		bit got;
		got = 0;
		@(posedge clk) txd_n <= 0;
		cyc(3);
		for (int n = 0; n < 200 && !got; n++)
		begin
			cyc(1);
			got = !line.drive_h;
		end
		if (!got) timeout();
		rd(STAT_OFS, v);
		chk(v[8], 1);
		chk(line.drive_l, 0);
		@(posedge clk) txd_n <= 1;
		cyc(3);
		rd(STAT_OFS, v);
		chk(v[8], 0);
		rd(8'h40, v);
		chk(v, 0);
		chk(resp, RESP_ERR);
	endtask : t_txblock
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 0;
		cyc(1);
		t_reset();
		t_standby();
		t_receive_only_mode_sleep();
		t_normal();
		t_faults();
		t_txblock();
		end_of_test();
	end
endmodule : csm_supply_mode_fault_manager_tb
